/* rtl/rtc_pkg.sv */
// constants shared by the time, alarm and stamp register block
package rtc_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int HALF_SEC_MS = 500;
  localparam int HALF_SEC_CYCLES = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int SYNC_LEAD_CYCLES = 32;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_TIME_SEC = 8'h00;
  localparam logic [7:0] OFS_TIME_HM = 8'h04;
  localparam logic [7:0] OFS_DATE_DW = 8'h08;
  localparam logic [7:0] OFS_DATE_YM = 8'h0C;
  localparam logic [7:0] OFS_ALM_SEC = 8'h10;
  localparam logic [7:0] OFS_ALM_HM = 8'h14;
  localparam logic [7:0] OFS_ALM_DW = 8'h18;
  localparam logic [7:0] OFS_ALM_YM = 8'h1C;
  localparam logic [7:0] OFS_STAMP_SEC = 8'h20;
  localparam logic [7:0] OFS_CTRL = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_INT_EN = 8'h2C;
  localparam logic [7:0] OFS_INT_CLR = 8'h30;
  // ****************************************
  // implemented bits of each word
  // ****************************************
  localparam logic [15:0] MASK_SEC = 16'h7F00;
  localparam logic [15:0] MASK_HM = 16'h3F7F;
  localparam logic [15:0] MASK_DW = 16'h3F07;
  localparam logic [15:0] MASK_YM = 16'hFF1F;
  localparam logic [15:0] MASK_CTRL = 16'h8F01;
  localparam logic [15:0] MASK_EVT = 16'h0028;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // ****************************************
  // control and status bit positions
  // ****************************************
  localparam int CTL_AEN_BIT = 15;
  localparam int CTL_ALARM_INTERVAL_MASK_LSB = 8;
  localparam int CTL_TRIG_BIT = 1;
  localparam int CTL_SEN_BIT = 0;
  localparam int ST_ALM_BIT = 5;
  localparam int ST_STAMP_BIT = 3;
  localparam int ST_SYNC_BIT = 2;
  localparam int ST_HALF_BIT = 0;
  // ****************************************
  // alarm interval codes
  // ****************************************
  localparam logic [3:0] AM_HALF = 4'h0;
  localparam logic [3:0] AM_SEC = 4'h1;
  localparam logic [3:0] AM_TEN_SEC = 4'h2;
  localparam logic [3:0] AM_MIN = 4'h3;
  localparam logic [3:0] AM_TEN_MIN = 4'h4;
  localparam logic [3:0] AM_HOUR = 4'h5;
  localparam logic [3:0] AM_DAY = 4'h6;
  localparam logic [3:0] AM_WEEK = 4'h7;
  localparam logic [3:0] AM_MONTH = 4'h8;
  localparam logic [3:0] AM_YEAR = 4'h9;
endpackage : rtc_pkg

/* rtl/rtc_regs.sv */
// bcd time, date, alarm and stamp registers behind a wishbone slave
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - seconds tens in bits 14-12 (0..5), units in bits 11-8 (0..9).
// - minutes tens in bits 6-4 (0..5), units in bits 3-0.
// - hours tens in bits 13-12 (0..2), units in bits 11-8 (0..9).
// - day tens in bits 13-12 (0..3), units in bits 11-8 (0..9).
// - weekday is three bits 2-0, values 0 to 6.
// - month tens single bit 4 (0..1), units in bits 3-0.
// - year tens in bits 15-12, units in bits 11-8.
// - unused bits ignore writes and read zero.
// - alarm words share the time layout and reset to zero.
// - stamp word is plain storage when capture is off, kept over soft reset.
// - sync flag is high while time may change under a read.
// - interval mask picks which alarm digits must match.
// - stamp event copies the seconds word; capture valid once the flag reads one.
module rtc_regs
  import rtc_pkg::*;
#(
  parameter int HALF_CYCLES = rtc_pkg::HALF_SEC_CYCLES,
  parameter int SYNC_LEAD = rtc_pkg::SYNC_LEAD_CYCLES
)(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SOFT_RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic STAMP_EVENT,
  output logic ALARM_EVENT,
  output logic SYNC_STATUS,
  output logic IRQ
);
  import rtc_pkg::*;

  initial
  begin
    if (HALF_CYCLES < SYNC_LEAD + 4 || SYNC_LEAD < 1)
      $error("half second too short for the sync lead");
  end

  // ****************************************
  // state
  // ****************************************
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [15:0] tsec_ff, thm_ff, ddw_ff, dym_ff;
  logic [15:0] asec_ff, ahm_ff, adw_ff, aym_ff;
  logic [15:0] stamp_ff, ctrl_ff, int_en_ff;
  logic alm_flag_ff, stamp_flag_ff, sync_ff, half_ff, chk_half_ff, chk_sec_ff, alm_pulse_ff;
  logic [31:0] sub_cnt_ff;
  logic [15:0] nxt_tsec, nxt_thm, nxt_ddw, nxt_dym;
  logic [15:0] status;
  logic req, wr, tick_half, sec_tick, capture, alarm_hit, match;
  logic [7:0] last_day;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
    merge[15:8] = (WB_SEL_I[1] ? WB_DAT_I[15:8] : old[15:8]) & mask[15:8];
    merge[7:0] = (WB_SEL_I[0] ? WB_DAT_I[7:0] : old[7:0]) & mask[7:0];
  endfunction : merge

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = wr && (WB_ADR_I == ofs);
  endfunction : wr_at

  // ****************************************
  // wishbone slave, one wait state
  // ****************************************
  assign req = WB_CYC_I && WB_STB_I;
  assign wr = req && WB_WE_I && ack_ff;

  always_ff @(posedge CLK)
  begin
    if (RST)
      ack_ff <= 1'b0;
    else
      ack_ff <= req && !ack_ff;
  end

  // unmapped offsets and the clear register read as zero
  always_ff @(posedge CLK)
  begin
    if (RST)
      dat_ff <= 32'h0000_0000;
    else if (req && !ack_ff)
    begin
      case (WB_ADR_I)
        OFS_TIME_SEC: dat_ff <= {16'h0000, tsec_ff};
        OFS_TIME_HM: dat_ff <= {16'h0000, thm_ff};
        OFS_DATE_DW: dat_ff <= {16'h0000, ddw_ff};
        OFS_DATE_YM: dat_ff <= {16'h0000, dym_ff};
        OFS_ALM_SEC: dat_ff <= {16'h0000, asec_ff};
        OFS_ALM_HM: dat_ff <= {16'h0000, ahm_ff};
        OFS_ALM_DW: dat_ff <= {16'h0000, adw_ff};
        OFS_ALM_YM: dat_ff <= {16'h0000, aym_ff};
        OFS_STAMP_SEC: dat_ff <= {16'h0000, stamp_ff};
        OFS_CTRL: dat_ff <= {16'h0000, ctrl_ff};
        OFS_STATUS: dat_ff <= {16'h0000, status};
        OFS_INT_EN: dat_ff <= {16'h0000, int_en_ff};
        default: dat_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;

  // ****************************************
  // half-second divider and sync window
  // ****************************************
  assign tick_half = (sub_cnt_ff == 32'(HALF_CYCLES - 1));
  assign sec_tick = tick_half && half_ff;

  // a write of the seconds word restarts the second, so a set time is exact
  always_ff @(posedge CLK)
  begin
    if (RST || wr_at(OFS_TIME_SEC))
    begin
      sub_cnt_ff <= 32'h0000_0000;
      half_ff <= 1'b0;
    end
    else if (tick_half)
    begin
      sub_cnt_ff <= 32'h0000_0000;
      half_ff <= !half_ff;
    end
    else
      sub_cnt_ff <= sub_cnt_ff + 32'h0000_0001;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      sync_ff <= 1'b0;
    else
      sync_ff <= half_ff && (sub_cnt_ff >= 32'(HALF_CYCLES - 2 - SYNC_LEAD)) && !tick_half;
  end

  assign SYNC_STATUS = sync_ff;

  // ****************************************
  // bcd calendar increment
  // ****************************************
  always_comb
  begin
    last_day = 8'h31;
    case (dym_ff[4:0])
      5'h02: last_day = (dym_ff[12] ? (dym_ff[11:8] == 4'h2 || dym_ff[11:8] == 4'h6)
                         : (dym_ff[11:8] == 4'h0 || dym_ff[11:8] == 4'h4 ||
                            dym_ff[11:8] == 4'h8)) ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  end

  always_comb
  begin
    nxt_tsec = tsec_ff;
    nxt_thm = thm_ff;
    nxt_ddw = ddw_ff;
    nxt_dym = dym_ff;
    if (tsec_ff[11:8] != 4'h9)
      nxt_tsec[11:8] = tsec_ff[11:8] + 4'h1;
    else if (tsec_ff[14:12] != 3'h5)
      nxt_tsec = {1'b0, tsec_ff[14:12] + 3'h1, 4'h0, 8'h00};
    else
    begin
      nxt_tsec = WORD_RESET;
      if (thm_ff[3:0] != 4'h9)
        nxt_thm[3:0] = thm_ff[3:0] + 4'h1;
      else if (thm_ff[6:4] != 3'h5)
        nxt_thm[7:0] = {1'b0, thm_ff[6:4] + 3'h1, 4'h0};
      else
      begin
        nxt_thm[7:0] = 8'h00;
        if (thm_ff[13:8] == 6'h23)
        begin
          nxt_thm[13:8] = 6'h00;
          nxt_ddw[2:0] = (ddw_ff[2:0] >= 3'h6) ? 3'h0 : ddw_ff[2:0] + 3'h1;
          if (ddw_ff[15:8] == last_day)
          begin
            nxt_ddw[13:8] = 6'h01;
            if (dym_ff[4:0] == 5'h12)
            begin
              nxt_dym[4:0] = 5'h01;
              if (dym_ff[11:8] != 4'h9)
                nxt_dym[11:8] = dym_ff[11:8] + 4'h1;
              else
                nxt_dym[15:8] = (dym_ff[15:12] == 4'h9) ? 8'h00 : {dym_ff[15:12] + 4'h1, 4'h0};
            end
            else if (dym_ff[3:0] == 4'h9)
              nxt_dym[4:0] = 5'h10;
            else
              nxt_dym[3:0] = dym_ff[3:0] + 4'h1;
          end
          else if (ddw_ff[11:8] == 4'h9)
            nxt_ddw[13:8] = {ddw_ff[13:12] + 2'h1, 4'h0};
          else
            nxt_ddw[11:8] = ddw_ff[11:8] + 4'h1;
        end
        else if (thm_ff[11:8] == 4'h9)
          nxt_thm[13:8] = {thm_ff[13:12] + 2'h1, 4'h0};
        else
          nxt_thm[11:8] = thm_ff[11:8] + 4'h1;
      end
    end
  end

  // ****************************************
  // live time and date; a software write beats the tick
  // ****************************************
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      tsec_ff <= WORD_RESET;
      thm_ff <= WORD_RESET;
      ddw_ff <= WORD_RESET;
      dym_ff <= WORD_RESET;
    end
    else
    begin
      tsec_ff <= wr_at(OFS_TIME_SEC) ? merge(tsec_ff, MASK_SEC) : sec_tick ? nxt_tsec : tsec_ff;
      thm_ff <= wr_at(OFS_TIME_HM) ? merge(thm_ff, MASK_HM) : sec_tick ? nxt_thm : thm_ff;
      ddw_ff <= wr_at(OFS_DATE_DW) ? merge(ddw_ff, MASK_DW) : sec_tick ? nxt_ddw : ddw_ff;
      dym_ff <= wr_at(OFS_DATE_YM) ? merge(dym_ff, MASK_YM) : sec_tick ? nxt_dym : dym_ff;
    end
  end

  // ****************************************
  // alarm words and control
  // ****************************************
  always_ff @(posedge CLK)
  begin
    if (RST || SOFT_RST)
    begin
      asec_ff <= WORD_RESET;
      ahm_ff <= WORD_RESET;
      adw_ff <= WORD_RESET;
      aym_ff <= WORD_RESET;
    end
    else
    begin
      // no lockout while armed: a rewrite then may raise a false alarm
      if (wr_at(OFS_ALM_SEC)) asec_ff <= merge(asec_ff, MASK_SEC);
      if (wr_at(OFS_ALM_HM)) ahm_ff <= merge(ahm_ff, MASK_HM);
      if (wr_at(OFS_ALM_DW)) adw_ff <= merge(adw_ff, MASK_DW);
      if (wr_at(OFS_ALM_YM)) aym_ff <= merge(aym_ff, MASK_YM);
    end
  end

  // the trigger bit never stores, it only fires a capture
  always_ff @(posedge CLK)
  begin
    if (RST || SOFT_RST)
      ctrl_ff <= WORD_RESET;
    else if (wr_at(OFS_CTRL))
      ctrl_ff <= merge(ctrl_ff, MASK_CTRL) & ~(16'h0001 << CTL_TRIG_BIT);
    else if (alarm_hit)
      ctrl_ff[CTL_AEN_BIT] <= 1'b0;
  end

  // ****************************************
  // alarm compare, one cycle after the time moved
  // ****************************************
  always_comb
  begin
    match = 1'b0;
    case (ctrl_ff[CTL_ALARM_INTERVAL_MASK_LSB +: 4])
      AM_SEC: match = 1'b1;
      AM_TEN_SEC: match = (tsec_ff[11:8] == asec_ff[11:8]);
      AM_MIN: match = (tsec_ff == asec_ff);
      AM_TEN_MIN: match = (tsec_ff == asec_ff) && (thm_ff[3:0] == ahm_ff[3:0]);
      AM_HOUR: match = (tsec_ff == asec_ff) && (thm_ff[7:0] == ahm_ff[7:0]);
      AM_DAY: match = (tsec_ff == asec_ff) && (thm_ff == ahm_ff);
      AM_WEEK: match = (tsec_ff == asec_ff) && (thm_ff == ahm_ff) && (ddw_ff[2:0] == adw_ff[2:0]);
      AM_MONTH: match = (tsec_ff == asec_ff) && (thm_ff == ahm_ff) && (ddw_ff[15:8] == adw_ff[15:8]);
      AM_YEAR: match = (tsec_ff == asec_ff) && (thm_ff == ahm_ff) &&
                       (ddw_ff[15:8] == adw_ff[15:8]) && (dym_ff[4:0] == aym_ff[4:0]);
      default: match = 1'b0;
    endcase
  end

  assign alarm_hit = ctrl_ff[CTL_AEN_BIT] &&
    ((ctrl_ff[CTL_ALARM_INTERVAL_MASK_LSB +: 4] == AM_HALF) ? chk_half_ff : (chk_sec_ff && match));

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      chk_half_ff <= 1'b0;
      chk_sec_ff <= 1'b0;
      alm_pulse_ff <= 1'b0;
    end
    else
    begin
      chk_half_ff <= tick_half;
      chk_sec_ff <= sec_tick;
      alm_pulse_ff <= alarm_hit;
    end
  end

  assign ALARM_EVENT = alm_pulse_ff;

  // ****************************************
  // timestamp word, kept through soft reset
  // ****************************************
  assign capture = ctrl_ff[CTL_SEN_BIT] &&
    (STAMP_EVENT || (wr_at(OFS_CTRL) && WB_SEL_I[0] && WB_DAT_I[CTL_TRIG_BIT]));

  always_ff @(posedge CLK)
  begin
    if (RST)
      stamp_ff <= WORD_RESET;
    else if (capture)
      stamp_ff <= tsec_ff;
    else if (wr_at(OFS_STAMP_SEC))
      stamp_ff <= merge(stamp_ff, MASK_SEC);
  end

  // ****************************************
  // sticky events and interrupt; set wins over clear
  // ****************************************
  always_ff @(posedge CLK)
  begin
    if (RST || SOFT_RST)
    begin
      alm_flag_ff <= 1'b0;
      stamp_flag_ff <= 1'b0;
    end
    else
    begin
      alm_flag_ff <= alarm_hit ||
        (alm_flag_ff && !(wr_at(OFS_INT_CLR) && WB_SEL_I[0] && WB_DAT_I[ST_ALM_BIT]));
      stamp_flag_ff <= capture ||
        (stamp_flag_ff && !(wr_at(OFS_INT_CLR) && WB_SEL_I[0] && WB_DAT_I[ST_STAMP_BIT]));
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST || SOFT_RST)
      int_en_ff <= WORD_RESET;
    else if (wr_at(OFS_INT_EN))
      int_en_ff <= merge(int_en_ff, MASK_EVT);
  end

  always_comb
  begin
    status = WORD_RESET;
    status[ST_ALM_BIT] = alm_flag_ff;
    status[ST_STAMP_BIT] = stamp_flag_ff;
    status[ST_SYNC_BIT] = sync_ff;
    status[ST_HALF_BIT] = half_ff;
  end

  assign IRQ = |(status & int_en_ff & MASK_EVT);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  ack_single_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held two cycles");
  ack_latency_a: assert property (req && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack not given one cycle after request");
  sec_rollover_a: assert property (sec_tick && !wr && tsec_ff == 16'h5900 |=> tsec_ff == 16'h0000)
    else $error("seconds did not wrap at 59");
  day_rollover_a: assert property (sec_tick && !wr && tsec_ff == 16'h5900 && thm_ff == 16'h2359
    |=> thm_ff == 16'h0000)
    else $error("hours and minutes did not wrap at 23:59:59");
  weekday_range_a: assert property (sec_tick && !wr && ddw_ff[2:0] <= 3'h6 |=> ddw_ff[2:0] <= 3'h6)
    else $error("weekday left 0..6");
  reserved_zero_a: assert property (((tsec_ff | asec_ff | stamp_ff) & ~MASK_SEC) == 16'h0000 &&
    ((thm_ff | ahm_ff) & ~MASK_HM) == 16'h0000 && ((dym_ff | aym_ff) & ~MASK_YM) == 16'h0000)
    else $error("unused bit set");
  sync_covers_tick_a: assert property (sec_tick && $past(!wr_at(OFS_TIME_SEC), 2) |-> $past(sync_ff))
    else $error("sync low just before the time changed");
  alarm_disarms_a: assert property (alarm_hit && !wr && !SOFT_RST |=>
    !ctrl_ff[CTL_AEN_BIT] && alm_flag_ff && ALARM_EVENT)
    else $error("alarm did not flag and disarm");
  stamp_copy_a: assert property (capture && !SOFT_RST |=> stamp_ff == $past(tsec_ff) && stamp_flag_ff)
    else $error("stamp not captured");
  irq_follows_a: assert property (alarm_hit && int_en_ff[ST_ALM_BIT] && !wr && !SOFT_RST |=> IRQ)
    else $error("enabled event did not raise the interrupt");

  alarm_fire_c: cover property (alarm_hit ##1 IRQ);
  minute_carry_c: cover property (sec_tick && tsec_ff == 16'h5900);
  stamp_capture_c: cover property (capture ##1 stamp_flag_ff);
  read_time_c: cover property (req && !WB_WE_I && WB_ADR_I == OFS_TIME_SEC ##1 WB_ACK_O);
endmodule : rtc_regs

/* test/tb.sv */
// self-checking bench for the bcd time, alarm and stamp register block
`timescale 1ns/1ps
module tb;
  import rtc_pkg::*;
  localparam int HC = 64;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic stamp_evt = 1'b0;
  logic alarm_evt;
  logic sync_st;
  logic irq;
  logic [31:0] rdv;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] msk [5] = '{MASK_SEC, MASK_HM, MASK_DW, MASK_YM, MASK_SEC};

  rtc_regs #(.HALF_CYCLES(HC), .SYNC_LEAD(4)) DUT (.CLK(clk), .RST(rst), .SOFT_RST(soft_rst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .STAMP_EVENT(stamp_evt),
    .ALARM_EVENT(alarm_evt), .SYNC_STATUS(sync_st), .IRQ(irq));

  always #50 clk = ~clk;

  // ****************************************
  // run limit and verdict
  // ****************************************
  // ceiling sized for about two thousand cycles of tests, with margin
  always @(posedge clk)
  begin
    cycles++;
    if (cycles >= 12000)
    begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (errors == 0 && samples_checked > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // ****************************************
  // wishbone classic master
  // ****************************************
  // no fixed latency assumed: wait for ack, bounded so a dead slave shows up
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rdv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    check("bus ack", 1, n < 20);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string what);
    wb(1'b0, a, 16'h0000);
    check(what, {16'h0000, e}, rdv);
  endtask : rd

  task automatic pulse_stamp();
    @(posedge clk);
    stamp_evt <= 1'b1;
    @(posedge clk);
    stamp_evt <= 1'b0;
  endtask : pulse_stamp

  task automatic hard_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : hard_reset

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power_on();
    for (int i = 0; i < 9; i++)
      rd(8'(i * 4), 16'h0000, "word after power-on");
    rd(8'h3C, 16'h0000, "unmapped read");
    check("irq after reset", 0, irq);
  endtask : t_power_on

  task automatic t_unused_bits();
    for (int i = 4; i < 9; i++)
    begin
      wr(8'(i * 4), 16'hFFFF);
      rd(8'(i * 4), msk[i - 4], "implemented bits");
    end
  endtask : t_unused_bits

  // 23:59:59 on 31 dec 99, weekday 6, must roll every digit at one tick
  task automatic t_rollover();
    int n;
    n = 0;
    wr(OFS_TIME_HM, 16'hE3D9);
    wr(OFS_DATE_DW, 16'hF1FE);
    wr(OFS_DATE_YM, 16'h99F2);
    wr(OFS_TIME_SEC, 16'hD9FF);
    rd(OFS_TIME_SEC, 16'h5900, "seconds field");
    rd(OFS_TIME_HM, 16'h2359, "hours minutes fields");
    rd(OFS_DATE_DW, 16'h3106, "day weekday fields");
    rd(OFS_DATE_YM, 16'h9912, "year month fields");
    repeat (2 * HC + 8)
    begin
      @(posedge clk);
      if (sync_st === 1'b1)
        n++;
    end
    check("sync high only late in second", 1, n > 0 && n < HC);
    rd(OFS_TIME_SEC, 16'h0000, "seconds wrap");
    rd(OFS_TIME_HM, 16'h0000, "hours minutes wrap");
    rd(OFS_DATE_DW, 16'h0100, "day and weekday wrap");
    rd(OFS_DATE_YM, 16'h0001, "month and year wrap");
  endtask : t_rollover

  task automatic t_stamp();
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_STAMP_SEC, 16'hFFFF);
    pulse_stamp();
    rd(OFS_STAMP_SEC, 16'h7F00, "stamp word as storage");
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    rd(OFS_STAMP_SEC, 16'h7F00, "stamp kept over soft reset");
    rd(OFS_DATE_YM, 16'h0001, "date kept over soft reset");
    for (int i = 4; i < 8; i++)
      rd(8'(i * 4), 16'h0000, "alarm word soft reset");
    wr(OFS_CTRL, 16'h0001);
    wr(OFS_INT_EN, 16'h0008);
    wr(OFS_TIME_SEC, 16'h4200);
    pulse_stamp();
    rd(OFS_STAMP_SEC, 16'h4200, "stamp capture by event");
    check("stamp read upper half", 32'h0000_0000, {16'h0000, rdv[31:16]});
    wb(1'b0, OFS_STATUS, 16'h0000);
    check("stamp flag set", 1, rdv[ST_STAMP_BIT]);
    @(negedge clk);
    check("irq on stamp", 1, irq);
    wr(OFS_INT_EN, 16'h0000);
    @(negedge clk);
    check("irq masked", 0, irq);
    wr(OFS_INT_EN, 16'h0008);
    wr(OFS_INT_CLR, 16'h0008);
    @(negedge clk);
    check("irq cleared", 0, irq);
    wr(OFS_TIME_SEC, 16'h1700);
    wr(OFS_CTRL, 16'h0003);
    rd(OFS_STAMP_SEC, 16'h1700, "stamp capture by trigger");
    wb(1'b0, OFS_STATUS, 16'h0000);
    check("stamp flag by trigger", 1, rdv[ST_STAMP_BIT]);
    wr(OFS_INT_CLR, 16'h0008);
    wr(OFS_CTRL, 16'h0000);
  endtask : t_stamp

  // alarm words other than seconds are zero, live time is 00:00 day 01 weekday 0, seconds restarted at 00
  task automatic t_alarm(input logic [3:0] m, input int hi);
    int n;
    n = 0;
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_INT_CLR, 16'h0020);
    wr(OFS_TIME_SEC, 16'h0000);
    wr(OFS_ALM_SEC, 16'h0100);
    wr(OFS_INT_EN, 16'h0020);
    wr(OFS_CTRL, {4'h8, m, 8'h00});
    while (alarm_evt !== 1'b1 && n < 3 * HC)
    begin
      @(posedge clk);
      n++;
    end
    if (hi == 0)
    begin
      check("alarm absent", 1, n >= 3 * HC);
    end
    else
    begin
      check("alarm delay", 1, n >= hi - 12 && n <= hi);
      @(negedge clk);
      check("alarm irq", 1, irq);
      rd(OFS_CTRL, {8'h00 | m, 8'h00}, "alarm enable cleared");
    end
  endtask : t_alarm

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_power_on();
    t_unused_bits();
    t_rollover();
    t_stamp();
    for (int m = 0; m < 11; m++)
      t_alarm(4'(m), (m == 0) ? HC : ((m < 8) ? 2 * HC : 0));
    hard_reset();
    t_power_on();
    end_sim();
  end
endmodule : tb
